// >>> include/eeprom_pkg.sv
// Constants shared by the serial memory front end and its write timer
package eeprom_pkg;
   // ************************************************************
   // Opcodes
   // ************************************************************
   localparam logic [7:0] OP_SET_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_MEM_MASK    = 8'hF7;   // Bit 3 carries the top address bit
   localparam logic [7:0] OP_READ_MEM    = 8'h03;
   localparam logic [7:0] OP_WRITE_MEM   = 8'h02;
   localparam int         OP_ADDR_HI_BIT = 3;

   // ************************************************************
   // Array and page geometry
   // ************************************************************
   localparam int         ADDR_W      = 9;
   localparam int         MEM_DEPTH   = 512;
   localparam int         PAGE_W      = 4;
   localparam int         PAGE_BYTES  = 16;
   localparam logic [2:0] BIT_LAST    = 3'h7;

   // ************************************************************
   // Status layout
   // ************************************************************
   localparam int         ST_BUSY_BIT = 0;
   localparam int         ST_LATCH_BIT = 1;
   localparam int         ST_PROT_LO  = 2;
   localparam int         ST_PROT_HI  = 3;
   localparam logic [3:0] ST_FIXED_HI = 4'hF;     // Upper status bits read as ones
   localparam logic [1:0] PROT_RESET  = 2'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int         CLK_MHZ       = 200;
   localparam int         WRITE_TIME_MS = 5;
   localparam int         WRITE_CYCLES  = WRITE_TIME_MS * CLK_MHZ * 1000;
   localparam int         TIMER_W       = 21;

   typedef enum logic [2:0] {
      ST_OPCODE, ST_ADDR, ST_READ, ST_STATUS, ST_WDATA, ST_WSTAT, ST_IGNORE
   } seq_state_t;
endpackage : eeprom_pkg

// >>> hdl/write_cycle_timer.sv
// Self-timed write cycle counter
`timescale 1ns/100ps
module write_cycle_timer #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   // Clock, reset and enable
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // Control
   input  wire logic start_i,
   output logic      busy_o
);
   localparam logic [eeprom_pkg::TIMER_W-1:0] LAST = eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1);
   logic [eeprom_pkg::TIMER_W-1:0] cnt_r;

   // Counter runs from start until the cycle budget is spent
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         cnt_r  <= '0;
         busy_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start_i && !busy_o)
         begin
            cnt_r  <= '0;
            busy_o <= 1'b1;
         end
         // [RULE11] bounded cycle
         else if (busy_o)
         begin
            cnt_r  <= cnt_r + 1'b1;
            busy_o <= (cnt_r != LAST);
         end
      end
   end

   default clocking cb @(posedge ref_clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   AST_WRITE_BOUNDED: assert property (busy_o && (cnt_r == LAST) |=> !busy_o) // [RULE11]
      else $error("write cycle ran past its limit");
endmodule : write_cycle_timer

// >>> hdl/spi_eeprom_core.sv
// Serial command front end and byte array of a small serial memory
// Overview of operation
// [RULE1] First eight bits after select falls form the opcode.
// [RULE2] Six opcodes; 06h sets, 04h clears the write latch.
// [RULE3] 05h shifts status out; 01h loads status from the next byte.
// [RULE4] Read opcode 0000 X011, X is address bit 8.
// [RULE5] Write opcode 0000 X010, X is address bit 8.
// [RULE6] Input bits are sampled on rising serial clock edges.
// [RULE7] Output changes on falling serial clock edges.
// [RULE8] Select high floats the output; standby unless writing.
// [RULE9] Host frames every sequence with a select falling edge.
// [RULE10] Internal write starts only at select rising after a valid write.
// [RULE11] Internal write finishes within 5 ms.
// [RULE12] Write protect low inhibits every write.
// [RULE13] Protect low during select aborts pending write; running cycle unaffected.
// [RULE14] Hold pauses the sequence, state kept across the pause.
// [RULE15] While held, output floats and input is ignored.
// [RULE16] Host keeps hold high when not pausing.
// [RULE17] Host waits up to 1 ms after power before first access.
// [RULE18] Status bit 0 is one while a write cycle runs.
// [RULE19] Status write changes only bits 2 and 3.
// [RULE20] During a write cycle only status read is accepted.
// [RULE21] Page write wraps within a 16-byte page.
// [RULE22] Most significant bit first; address follows opcode, data follows address.
// [RULE23] Writes need the latch set by an earlier completed sequence.
`timescale 1ns/100ps
module spi_eeprom_core #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   // Clock, reset, enable
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // Serial pins
   input  wire logic cs_n_i,
   input  wire logic sck_i,
   input  wire logic si_i,
   input  wire logic wp_n_i,
   input  wire logic hold_n_i,
   output logic      so_o,
   output logic      so_oe_n_o
);
   // ************************************************************
   // Pin synchronisers and edge detection
   // ************************************************************
   localparam int P_CS = 0, P_SCK = 1, P_SI = 2, P_WP = 3, P_HOLD = 4;
   logic [4:0] pin_meta_r;
   logic [4:0] pin_s_r;
   logic       cs_d_r;
   logic       sck_d_r;

   // Two stages on every pin; the link clock is only sampled here
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         pin_meta_r <= 5'h19;
         pin_s_r    <= 5'h19;
         cs_d_r     <= 1'b1;
         sck_d_r    <= 1'b0;
      end
      else if (ce_i)
      begin
         pin_meta_r <= {hold_n_i, wp_n_i, si_i, sck_i, cs_n_i};
         pin_s_r    <= pin_meta_r;
         cs_d_r     <= pin_s_r[P_CS];
         sck_d_r    <= pin_s_r[P_SCK];
      end
   end

   wire cs_s     = pin_s_r[P_CS];
   wire si_s     = pin_s_r[P_SI];
   wire wp_s     = pin_s_r[P_WP];
   wire hold_s   = pin_s_r[P_HOLD];
   // [RULE9] framing edges
   wire cs_fall  = !cs_s && cs_d_r;
   wire cs_rise  = cs_s && !cs_d_r;
   // [RULE14] [RULE15] held link sees no edges, so the sequence state simply waits
   wire active   = !cs_s && hold_s;
   // [RULE6] sample edge
   wire sck_rise = active && pin_s_r[P_SCK] && !sck_d_r;
   // [RULE7] shift-out edge
   wire sck_fall = active && !pin_s_r[P_SCK] && sck_d_r;

   // ************************************************************
   // Sequence state
   // ************************************************************
   eeprom_pkg::seq_state_t st_r;
   logic [7:0]                      sh_r;
   logic [2:0]                      bit_cnt_r;
   logic [7:0]                      op_r;
   logic [eeprom_pkg::ADDR_W-1:0]   addr_r;
   logic [7:0]                      out_sh_r;
   logic [2:0]                      out_cnt_r;
   logic                            drv_r;
   logic                            latch_r;
   logic [1:0]                      prot_r;
   logic [1:0]                      prot_pend_r;
   logic                            set_pend_r;
   logic                            mem_armed_r;
   logic                            stat_armed_r;
   logic                            abort_r;
   logic [eeprom_pkg::PAGE_BYTES-1:0] pg_valid_r;
   logic [7:0]                      pg_buf_r [eeprom_pkg::PAGE_BYTES];
   logic [7:0]                      mem_r [eeprom_pkg::MEM_DEPTH];
   logic                            busy;
   logic                            busy_d_r;

   // Opcode class tests, used by decode and by the address stage
   function automatic logic is_mem(input logic [7:0] op, input logic [7:0] code);
      is_mem = (op & eeprom_pkg::OP_MEM_MASK) == code;
   endfunction : is_mem

   // [RULE22] shift in msb first
   wire [7:0] byte_w    = {sh_r[6:0], si_s};
   wire       byte_done = sck_rise && (bit_cnt_r == eeprom_pkg::BIT_LAST);
   wire [eeprom_pkg::ADDR_W-1:0] addr_full = {op_r[eeprom_pkg::OP_ADDR_HI_BIT], byte_w};
   wire [eeprom_pkg::ADDR_W-1:0] addr_inc  = addr_r + 1'b1;
   // [RULE21] low address bits wrap inside the page
   wire [eeprom_pkg::PAGE_W-1:0] page_inc  = addr_r[eeprom_pkg::PAGE_W-1:0] + 1'b1;
   // [RULE18] busy flag in bit 0
   wire [7:0] status_w = {eeprom_pkg::ST_FIXED_HI, prot_r, latch_r, busy};
   // [RULE20] busy admits status read only
   wire       op_ok     = !busy || (byte_w == eeprom_pkg::OP_READ_STATUS);
   // [RULE10] valid write closed on a byte boundary
   wire       commit    = cs_rise && (mem_armed_r || stat_armed_r) && !abort_r
                          && wp_s && (bit_cnt_r == 3'h0) && !busy;

   // Bit counter and serial shift register
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || (ce_i && cs_fall))
      begin
         sh_r      <= 8'h00;
         bit_cnt_r <= 3'h0;
      end
      else if (ce_i && sck_rise)
      begin
         sh_r      <= byte_w;
         bit_cnt_r <= bit_cnt_r + 1'b1;
      end
   end

   // Command sequencer
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         st_r        <= eeprom_pkg::ST_IGNORE;
         op_r        <= 8'h00;
         addr_r      <= '0;
         set_pend_r  <= 1'b0;
         mem_armed_r <= 1'b0;
         stat_armed_r <= 1'b0;
         prot_pend_r <= eeprom_pkg::PROT_RESET;
         pg_valid_r  <= '0;
      end
      else if (ce_i)
      begin
         if (cs_fall)
         begin
            st_r         <= eeprom_pkg::ST_OPCODE;
            set_pend_r   <= 1'b0;
            mem_armed_r  <= 1'b0;
            stat_armed_r <= 1'b0;
            pg_valid_r   <= '0;
         end
         else if (byte_done)
         begin
            unique case (st_r)
               // [RULE1] opcode capture and decode
               eeprom_pkg::ST_OPCODE:
               begin
                  op_r <= byte_w;
                  if (!op_ok)
                     st_r <= eeprom_pkg::ST_IGNORE;
                  // [RULE2] latch commands
                  else if (byte_w == eeprom_pkg::OP_SET_LATCH)
                  begin
                     set_pend_r <= 1'b1;
                     st_r       <= eeprom_pkg::ST_IGNORE;
                  end
                  // [RULE3] status read and write
                  else if (byte_w == eeprom_pkg::OP_READ_STATUS)
                     st_r <= eeprom_pkg::ST_STATUS;
                  else if (byte_w == eeprom_pkg::OP_WRITE_STATUS && latch_r)
                     st_r <= eeprom_pkg::ST_WSTAT;
                  // [RULE4] [RULE5] memory opcodes carry address bit 8
                  else if (is_mem(byte_w, eeprom_pkg::OP_READ_MEM) ||
                           (is_mem(byte_w, eeprom_pkg::OP_WRITE_MEM) && latch_r))
                     st_r <= eeprom_pkg::ST_ADDR;
                  else
                     st_r <= eeprom_pkg::ST_IGNORE;
               end
               // [RULE22] address follows opcode
               eeprom_pkg::ST_ADDR:
               begin
                  addr_r <= addr_full;
                  st_r   <= is_mem(op_r, eeprom_pkg::OP_READ_MEM) ? eeprom_pkg::ST_READ
                                                                : eeprom_pkg::ST_WDATA;
               end
               // [RULE21] buffer bytes, wrap inside page
               eeprom_pkg::ST_WDATA:
               begin
                  pg_buf_r[addr_r[eeprom_pkg::PAGE_W-1:0]]   <= byte_w;
                  pg_valid_r[addr_r[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
                  addr_r[eeprom_pkg::PAGE_W-1:0]             <= page_inc;
                  mem_armed_r                                <= 1'b1;
               end
               // [RULE19] only the protect bits are kept
               eeprom_pkg::ST_WSTAT:
               begin
                  prot_pend_r  <= byte_w[eeprom_pkg::ST_PROT_HI:eeprom_pkg::ST_PROT_LO];
                  stat_armed_r <= 1'b1;
                  st_r         <= eeprom_pkg::ST_IGNORE;
               end
               eeprom_pkg::ST_READ,
               eeprom_pkg::ST_STATUS,
               eeprom_pkg::ST_IGNORE: ;
            endcase
         end
         else if (sck_fall && st_r == eeprom_pkg::ST_READ && out_cnt_r == eeprom_pkg::BIT_LAST)
            addr_r <= addr_inc;   // Sequential read rolls over the whole array
      end
   end

   // Abort flag: protect low at any point while selected kills the write
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || (ce_i && cs_fall))
         abort_r <= 1'b0;
      // [RULE13] abort pending write
      else if (ce_i && !cs_s && !wp_s)
         abort_r <= 1'b1;
   end

   // Write latch and protect bits
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         latch_r <= 1'b0;
         prot_r  <= eeprom_pkg::PROT_RESET;
      end
      else if (ce_i)
      begin
         // [RULE12] protect low forces write disable
         if (!wp_s)
            latch_r <= 1'b0;
         // [RULE23] latch set only once the enabling sequence is closed
         else if (cs_rise && set_pend_r)
            latch_r <= 1'b1;
         else if ((byte_done && st_r == eeprom_pkg::ST_OPCODE && op_ok &&
                   byte_w == eeprom_pkg::OP_CLEAR_LATCH) || (busy_d_r && !busy))
            latch_r <= 1'b0;
         if (commit && stat_armed_r)
            prot_r <= prot_pend_r;
      end
   end

   // Array update; the bytes buffered in the page (pg_valid_r set) land when the cycle starts
   always_ff @(posedge ref_clk_i)
   begin
      if (ce_i && commit && mem_armed_r)
      begin
         for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++)
         begin
            if (pg_valid_r[i])
               mem_r[{addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], eeprom_pkg::PAGE_W'(i)}] <= pg_buf_r[i];
         end
      end
   end

   // ************************************************************
   // Serial output
   // ************************************************************
   wire  out_state = (st_r == eeprom_pkg::ST_READ) || (st_r == eeprom_pkg::ST_STATUS);
   wire [7:0] reload = (st_r == eeprom_pkg::ST_READ) ? mem_r[addr_inc] : status_w;

   // Output shifter loads when the command completes and reloads every byte
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         out_sh_r  <= 8'h00;
         out_cnt_r <= 3'h0;
         drv_r     <= 1'b0;
         so_o      <= 1'b0;
         so_oe_n_o <= 1'b1;
         busy_d_r  <= 1'b0;
      end
      else if (ce_i)
      begin
         busy_d_r <= busy;
         if (cs_fall)
            drv_r <= 1'b0;
         else if (byte_done && st_r == eeprom_pkg::ST_ADDR)
         begin
            out_sh_r  <= mem_r[addr_full];
            out_cnt_r <= 3'h0;
         end
         else if (byte_done && st_r == eeprom_pkg::ST_OPCODE && byte_w == eeprom_pkg::OP_READ_STATUS)
         begin
            out_sh_r  <= status_w;
            out_cnt_r <= 3'h0;
         end
         // [RULE7] change output on falling edge
         else if (sck_fall && out_state)
         begin
            so_o      <= out_sh_r[7];
            drv_r     <= 1'b1;
            out_cnt_r <= out_cnt_r + 1'b1;
            out_sh_r  <= (out_cnt_r == eeprom_pkg::BIT_LAST) ? reload : {out_sh_r[6:0], 1'b0};
         end
         // [RULE8] [RULE15] float when deselected or held
         so_oe_n_o <= !(active && drv_r && out_state);
      end
   end

   // [RULE10] [RULE11] self-timed cycle
   write_cycle_timer #(
      .WRITE_CYCLES (WRITE_CYCLES)
   ) u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .start_i   (commit),
      .busy_o    (busy)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   sequence s_set_cmd;
      byte_done && st_r == eeprom_pkg::ST_OPCODE && op_ok && byte_w == eeprom_pkg::OP_SET_LATCH;
   endsequence
   AST_SET_PENDS: assert property (s_set_cmd |=> set_pend_r) // [RULE2]
      else $error("set command not held pending");
   AST_LATCH_AT_CLOSE: assert property ($rose(latch_r) |-> $past(cs_rise && set_pend_r)) // [RULE23]
      else $error("latch set outside a closing select edge");
   AST_SO_ON_FALL: assert property ($changed(so_o) |-> $past(sck_fall)) // [RULE7]
      else $error("output moved without a falling clock");
   AST_FLOAT_DESEL: assert property (cs_s |=> so_oe_n_o) // [RULE8]
      else $error("output driven while deselected");
   AST_HOLD_FREEZE: assert property (!hold_s |=> so_oe_n_o && $stable(bit_cnt_r)) // [RULE15]
      else $error("held link changed state");
   AST_START_ON_RISE: assert property ($rose(busy) |-> $past(cs_rise)) // [RULE10]
      else $error("write cycle started without select rising");
   AST_WP_CLEARS: assert property (!wp_s |=> !latch_r) // [RULE12]
      else $error("latch survived protect low");
   AST_BUSY_IGNORES: assert property (busy && byte_done && st_r == eeprom_pkg::ST_OPCODE &&
                                      byte_w != eeprom_pkg::OP_READ_STATUS |=> st_r == eeprom_pkg::ST_IGNORE) // [RULE20]
      else $error("command accepted during write cycle");
   AST_PROT_ONLY_COMMIT: assert property ($changed(prot_r) |-> $past(commit && stat_armed_r)) // [RULE19]
      else $error("protect bits changed outside a status write");
   AST_ABORT_NO_START: assert property (abort_r && cs_rise |=> !$rose(busy)) // [RULE13]
      else $error("aborted write still started");
endmodule : spi_eeprom_core

// >>> bench/spi_host_model.sv
// Host side model that frames commands and shifts bytes in modes (0,0) and (1,1)
`timescale 1ns/100ps
module spi_host_model (
   // Clock
   input  wire logic       ref_clk_i,
   // Serial pins
   input  wire logic       so_i,
   input  wire logic       so_oe_n_i,
   output logic            cs_n_o,
   output logic            sck_o,
   output logic            si_o,
   output logic            wp_n_o,
   output logic            hold_n_o,
   // Captured bytes
   output logic [7:0]      rx_byte_o,
   output logic            rx_valid_o
);
   // ************************************************************
   // Line resolution and serial tasks
   // ************************************************************
   localparam int HALF = 16;   // 80 ns half period at 200 MHz
   logic so_last_r = 1'b0;
   logic idle_hi_r = 1'b0;     // Clock idle level: low for (0,0), high for (1,1)
   logic so_line;

   // Released line shows the inverse of its last value, so a stale bit never passes
   assign so_line = so_oe_n_i ? ~so_last_r : so_i;

   // Remember the last driven level
   always @(posedge ref_clk_i)
   begin
      if (so_oe_n_i === 1'b0)
         so_last_r <= so_i;
   end

   initial
   begin
      cs_n_o     = 1'b1;
      sck_o      = 1'b0;
      si_o       = 1'b0;
      wp_n_o     = 1'b1;
      hold_n_o   = 1'b1;
      rx_byte_o  = 8'h00;
      rx_valid_o = 1'b0;
   end

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : cycles

   task automatic select(input logic lvl);
      cycles(HALF);
      cs_n_o <= lvl;
      cycles(HALF);
   endtask : select

   // Mode change only between frames, while select is high
   task automatic set_mode(input logic hi);
      @(posedge ref_clk_i);
      idle_hi_r = hi;
      sck_o <= hi;
   endtask : set_mode

   task automatic set_wp(input logic lvl);
      @(posedge ref_clk_i);
      wp_n_o <= lvl;
   endtask : set_wp

   // MSB first; hold moves only while clock is low
   task automatic xfer(input logic [7:0] tx, input int hold_at, input logic cap);
      logic [7:0] rx;
      rx = 8'h00;
      for (int b = 7; b >= 0; b--)
      begin
         // Shift-out fall; no change on the first bit in (0,0), where the clock idles low
         sck_o <= 1'b0;
         if (b == hold_at)
         begin
            cycles(HALF);              // Let the fall land before pausing
            hold_n_o <= 1'b0;
            cycles(HALF);
            si_o <= ~tx[b];            // Wrong bit clocked while paused
            sck_o <= 1'b1;
            cycles(HALF);
            sck_o <= 1'b0;
            cycles(HALF);
            hold_n_o <= 1'b1;
         end
         si_o <= tx[b];
         cycles(HALF);
         sck_o <= 1'b1;
         rx[b] = so_line;
         cycles(HALF);
      end
      sck_o <= idle_hi_r;
      if (cap)
      begin
         rx_byte_o  <= rx;
         rx_valid_o <= 1'b1;
         @(posedge ref_clk_i);
         rx_valid_o <= 1'b0;
      end
   endtask : xfer
endmodule : spi_host_model

// >>> bench/spi_serial_eeprom_interface_test.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/100ps
module spi_serial_eeprom_interface_test;
   // ************************************************************
   // Signals, design and host model
   // ************************************************************
   localparam int unsigned WCYC = 2000;   // Shortened write cycle
   logic       ref_clk = 1'b0;
   logic       rst     = 1'b1;
   logic       cs_n, sck, si, wp_n, hold_n, so, so_oe_n, rx_valid;
   logic       ce = 1'b1;
   logic [7:0] ce_lfsr_r = 8'h15;
   logic [7:0] rx_byte;
   logic [7:0] exp_q [$];
   logic [7:0] dat [3];
   logic [7:0] lfsr_r = 8'h15;
   int         failures = 0;
   int         check_count = 0;

   always #2.5 ref_clk = ~ref_clk;

   spi_eeprom_core #(.WRITE_CYCLES(WCYC)) i_spi_eeprom_core (.ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce),
      .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .hold_n_i(hold_n), .so_o(so), .so_oe_n_o(so_oe_n));

   spi_host_model i_spi_host_model (.ref_clk_i(ref_clk), .so_i(so), .so_oe_n_i(so_oe_n), .cs_n_o(cs_n),
      .sck_o(sck), .si_o(si), .wp_n_o(wp_n), .hold_n_o(hold_n), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   // Enable drops about one cycle in eight, so every stage must freeze and resume
   always @(posedge ref_clk)
   begin
      ce_lfsr_r <= lfsr_next(ce_lfsr_r);
      ce        <= |ce_lfsr_r[2:0];
   end

   task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected byte at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : check_byte

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // Watcher takes the oldest note whenever a byte arrives
   always @(posedge ref_clk)
   begin
      if (rx_valid === 1'b1)
         check_byte((exp_q.size() > 0) ? exp_q.pop_front() : ~rx_byte, rx_byte);
   end

   // ************************************************************
   // Transaction tasks
   // ************************************************************
   task automatic frame_cmd(input logic [7:0] op);
      i_spi_host_model.select(1'b0);
      i_spi_host_model.xfer(op, 8, 1'b0);
      i_spi_host_model.select(1'b1);
   endtask : frame_cmd

   task automatic read_status(input logic [7:0] exp);
      i_spi_host_model.select(1'b0);
      i_spi_host_model.xfer(eeprom_pkg::OP_READ_STATUS, 8, 1'b0);
      exp_q.push_back(exp);
      i_spi_host_model.xfer(8'h00, 8, 1'b1);
      i_spi_host_model.select(1'b1);
   endtask : read_status

   task automatic mem_write(input logic [8:0] a, input int n, input logic en);
      if (en)
         frame_cmd(eeprom_pkg::OP_SET_LATCH);
      i_spi_host_model.select(1'b0);
      i_spi_host_model.xfer(eeprom_pkg::OP_WRITE_MEM | {4'h0, a[8], 3'h0}, 8, 1'b0);
      i_spi_host_model.xfer(a[7:0], 8, 1'b0);
      for (int i = 0; i < n; i++)
         i_spi_host_model.xfer(dat[i], 8, 1'b0);
      i_spi_host_model.select(1'b1);
   endtask : mem_write

   task automatic mem_read(input logic [8:0] a, input int first, input int n, input int h);
      i_spi_host_model.select(1'b0);
      i_spi_host_model.xfer(eeprom_pkg::OP_READ_MEM | {4'h0, a[8], 3'h0}, 8, 1'b0);
      i_spi_host_model.xfer(a[7:0], h, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         exp_q.push_back(dat[first + i]);
         i_spi_host_model.xfer(8'h00, (i == 0) ? h : 8, 1'b1);
      end
      i_spi_host_model.select(1'b1);
   endtask : mem_read

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      i_spi_host_model.cycles(4);
      read_status(8'hF0);
      frame_cmd(eeprom_pkg::OP_SET_LATCH);
      read_status(8'hF2);
      frame_cmd(eeprom_pkg::OP_CLEAR_LATCH);
      read_status(8'hF0);
      $display("test latch commands done");
      for (int i = 0; i < 3; i++)
      begin
         lfsr_r = lfsr_next(lfsr_r);
         dat[i] = lfsr_r;
      end
      mem_write(9'h1FE, 3, 1'b1);
      frame_cmd(eeprom_pkg::OP_CLEAR_LATCH);
      read_status(8'hF3);
      i_spi_host_model.set_wp(1'b0);
      read_status(8'hF1);
      i_spi_host_model.set_wp(1'b1);
      i_spi_host_model.cycles(WCYC);
      read_status(8'hF0);
      mem_read(9'h1FE, 0, 2, 4);
      i_spi_host_model.set_mode(1'b1);
      mem_read(9'h1F0, 2, 1, 8);
      i_spi_host_model.set_mode(1'b0);
      $display("test page write done");
      lfsr_r = lfsr_next(lfsr_r);
      dat[1] = dat[0];
      dat[0] = dat[1] ^ (lfsr_r | 8'h01);                          // Always differs from the stored byte
      mem_write(9'h1FE, 1, 1'b0);
      read_status(8'hF0);
      frame_cmd(eeprom_pkg::OP_SET_LATCH);
      i_spi_host_model.set_wp(1'b0);
      mem_write(9'h1FE, 1, 1'b0);
      i_spi_host_model.set_wp(1'b1);
      i_spi_host_model.cycles(WCYC);
      mem_read(9'h1FE, 1, 1, 8);
      $display("test refused writes done");
      frame_cmd(eeprom_pkg::OP_SET_LATCH);
      i_spi_host_model.select(1'b0);
      i_spi_host_model.xfer(eeprom_pkg::OP_WRITE_STATUS, 8, 1'b0);
      i_spi_host_model.xfer(8'hFF, 8, 1'b0);
      i_spi_host_model.select(1'b1);
      i_spi_host_model.cycles(2 * WCYC);                           // Timer only counts while enabled
      read_status(8'hFC);
      $display("test status write done");
      i_spi_host_model.cycles(40);
      if (exp_q.size() != 0)
         failures++;
      give_verdict();
   end

   // Cut a hung run short
   initial
   begin
      repeat (90000) @(posedge ref_clk);
      failures++;
      give_verdict();
   end
endmodule : spi_serial_eeprom_interface_test
